// ==== srap_port.sv ====
/*
 * serial register-access port with a local register array.
 * a frame is select low, five instruction bits, eleven address bits, one data byte,
 * then select high; the top instruction bit picks read or write.
 * a finished write ignores further serial clocks until select goes high again.
 * assumes nothing else drives the serial output pin while its enable is low.
 * assumes the host keeps serial clock well below core_clk / 4 and holds select high
 * between transfers; select, serial clock and serial input are asynchronous pins.
 */
`timescale 1ns/10ps
`include "srap_params.svh"
module srap_port #(
    parameter int ADDR_BITS = `SRAP_ADDR_BITS,
    parameter int DATA_BITS = `SRAP_DATA_BITS,
    parameter int REG_COUNT = `SRAP_REG_COUNT
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic chipSel_n,
    input wire logic serialClk,
    input wire logic serial_in_line,
    output logic serial_out_line,
    output logic serialOutEn_n,
    output logic [ADDR_BITS-1:0] lastAddr,
    output logic lastWasRead,
    output logic writeStrobe,
    output logic [DATA_BITS-1:0] writeData
);
    // counter wide enough for the longest field, the address
    localparam int CNT_W = 5;
    localparam int IDX_W = $clog2(REG_COUNT);
    localparam logic [CNT_W-1:0] INSTR_LAST = CNT_W'(`SRAP_INSTR_BITS - 1);
    localparam logic [CNT_W-1:0] ADDR_LAST = CNT_W'(ADDR_BITS - 1);
    localparam logic [CNT_W-1:0] DATA_LAST = CNT_W'(DATA_BITS - 1);

    // all sequencer state in one word, registered once per clock
    typedef struct packed {
        srap_pkg::srap_phase_e phase;
        logic clkPrev;
        logic [CNT_W-1:0] bitCnt;
        logic [`SRAP_INSTR_BITS-1:0] instr;
        logic [ADDR_BITS-1:0] addr;
        logic [DATA_BITS-1:0] shift;
        logic isRead;
        logic outBit;
        logic outEn_n;
        logic [ADDR_BITS-1:0] lastAddr;
        logic lastWasRead;
        logic wrStb;
        logic [DATA_BITS-1:0] wrData;
        logic done; // write byte taken, wait for select high
    } srap_port_s;

    // registered state, its next value and the register file
    srap_port_s state;
    srap_port_s next_state;
    logic [DATA_BITS-1:0] regs [REG_COUNT];
    logic [DATA_BITS-1:0] rdByte;
    // synchronised pins and the edges found on them
    logic selSync_n;
    logic clkSync;
    logic dinSync;
    logic clkRise;
    logic clkFall;
    logic [IDX_W-1:0] regIdx;

    // every pin passes two flops; edges are found on core_clk
    // select resets high, its idle level, so leaving reset is not taken as a start
    srap_sync #(
        .RESET_VAL(1'b1)
    ) selSyncInst (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .asyncIn(chipSel_n),
        .syncOut(selSync_n)
    );
    // serial clock idles low, so the edge finder starts from low as well
    srap_sync #(
        .RESET_VAL(1'b0)
    ) clkSyncInst (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .asyncIn(serialClk),
        .syncOut(clkSync)
    );
    // data shares the clock's two-flop delay, so both stay aligned at a rise
    srap_sync #(
        .RESET_VAL(1'b0)
    ) dinSyncInst (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .asyncIn(serial_in_line),
        .syncOut(dinSync)
    );

    // serial clock edges; a pulse shorter than a core cycle is missed
    assign clkRise = clkSync & ~state.clkPrev;
    assign clkFall = ~clkSync & state.clkPrev;
    // addresses beyond the array alias modulo its size
    assign regIdx = state.addr[IDX_W-1:0];
    // byte picked by the address, loaded into the shifter on a read
    assign rdByte = regs[regIdx];

    // transfer sequencer: idle, instruction, address, data. each field but read data counts its own
    // rises from zero, so a frame cut anywhere just falls back to idle when select rises.
    // reads load the byte on the first fall after the address so the first bit stands
    // for a serial half period less the synchroniser delay before the host samples it.
    always_comb begin
        next_state = state;
        next_state.clkPrev = clkSync;
        next_state.wrStb = 1'b0;
        if (selSync_n) begin
            // select high ends any transfer, even a partial one [RULE_01]
            next_state.phase = srap_pkg::SRAP_IDLE;
            next_state.bitCnt = '0;
            next_state.outEn_n = 1'b1;
            // released output parks low so a stale bit never lingers
            next_state.outBit = 1'b0;
            next_state.done = 1'b0;
        end else begin
            unique case (state.phase)
                srap_pkg::SRAP_IDLE: begin
                    // a finished write waits here for select high; extra clocks are ignored
                    if (!state.done) begin
                        next_state.phase = srap_pkg::SRAP_INSTR; // low select starts [RULE_01]
                        next_state.bitCnt = '0;
                        next_state.isRead = 1'b0;
                    end
                end
                // instruction bits; the first one fixes the direction
                srap_pkg::SRAP_INSTR: begin
                    if (clkRise) begin
                        // msb first, sampled on rise [RULE_02] [RULE_07]
                        next_state.instr = {state.instr[`SRAP_INSTR_BITS-2:0], dinSync};
                        next_state.bitCnt = state.bitCnt + 1'b1;
                        if (state.bitCnt == '0) begin
                            next_state.isRead = (dinSync == `SRAP_READ_VALUE); // [RULE_03]
                        end
                        if (state.bitCnt == INSTR_LAST) begin
                            next_state.phase = srap_pkg::SRAP_ADDR;
                            next_state.bitCnt = '0;
                        end
                    end
                end
                // address bits; the full address is latched for the outputs
                srap_pkg::SRAP_ADDR: begin
                    if (clkRise) begin
                        next_state.addr = {state.addr[ADDR_BITS-2:0], dinSync}; // [RULE_04]
                        next_state.bitCnt = state.bitCnt + 1'b1;
                        if (state.bitCnt == ADDR_LAST) begin
                            next_state.phase = srap_pkg::SRAP_DATA;
                            next_state.bitCnt = '0;
                            next_state.lastAddr = {state.addr[ADDR_BITS-2:0], dinSync};
                            next_state.lastWasRead = state.isRead;
                        end
                    end
                end
                // data byte: shifted out on a read, shifted in on a write
                srap_pkg::SRAP_DATA: begin
                    if (state.isRead) begin
                        // load on the first fall after the address, then shift [RULE_05]
                        if (clkFall) begin
                            if (state.outEn_n) begin
                                next_state.shift = rdByte;
                                next_state.outBit = rdByte[DATA_BITS-1];
                                next_state.outEn_n = 1'b0;
                            end else begin
                                next_state.outBit = state.shift[DATA_BITS-2]; // [RULE_07]
                                next_state.shift = {state.shift[DATA_BITS-2:0], 1'b0};
                            end
                        end
                    end else if (clkRise) begin
                        // one byte, msb first, then committed [RULE_06] [RULE_07]
                        next_state.shift = {state.shift[DATA_BITS-2:0], dinSync};
                        next_state.bitCnt = state.bitCnt + 1'b1;
                        if (state.bitCnt == DATA_LAST) begin
                            // strobe for one cycle; the array takes the byte on the next edge
                            next_state.wrStb = 1'b1;
                            next_state.wrData = {state.shift[DATA_BITS-2:0], dinSync};
                            next_state.done = 1'b1;
                            next_state.phase = srap_pkg::SRAP_IDLE;
                            next_state.bitCnt = '0;
                        end
                    end
                end
                default: begin
                    next_state.phase = srap_pkg::SRAP_IDLE;
                end
            endcase
        end
    end

    // state word; reset leaves the port idle with the output released
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            // constants only; the array resets in its own process
            state <= '0;
            state.phase <= srap_pkg::SRAP_IDLE;
            state.outEn_n <= 1'b1;
            state.clkPrev <= 1'b0;
        end else begin
            state <= next_state;
        end
    end

    // register array; written once per completed write byte [RULE_06]
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < REG_COUNT; i++) begin
                regs[i] <= `SRAP_REG_RESET;
            end
        end else if (state.wrStb) begin
            regs[state.lastAddr[IDX_W-1:0]] <= state.wrData;
        end
    end

    // every output comes straight from a flop
    assign serial_out_line = state.outBit;
    assign serialOutEn_n = state.outEn_n;
    assign lastAddr = state.lastAddr;
    assign lastWasRead = state.lastWasRead;
    assign writeStrobe = state.wrStb;
    assign writeData = state.wrData;
endmodule

// ==== srap_params.svh ====
/*
 * constants of the serial register-access port: field widths, bit counts, timing.
 * assumes a 100 MHz core clock and a host serial clock well below it.
 */
`ifndef SRAP_PARAMS_SVH
`define SRAP_PARAMS_SVH
// Operation
// RULE_01 - a low select opens a transfer and a high select ends it, whatever state it is in.
// RULE_02 - five instruction bits follow the select and are sampled on serial clock rises.
// RULE_03 - the top instruction bit set means read, clear means write.
// RULE_04 - eleven address bits follow the instruction and pick the register.
// RULE_05 - on a read the register byte is shifted out, changing on serial clock falls.
// RULE_06 - on a write the data bits after the address are stored into the register.
// RULE_07 - the data phase is one byte, most significant bit first like the other fields.
`define SRAP_INSTR_BITS 5
`define SRAP_ADDR_BITS 11
`define SRAP_DATA_BITS 8
`define SRAP_READ_VALUE 1'b1
`define SRAP_CLK_PERIOD_NS 10
`define SRAP_OUT_DISABLE_NS 50
`define SRAP_OUT_DISABLE_CYC (`SRAP_OUT_DISABLE_NS / `SRAP_CLK_PERIOD_NS)
`define SRAP_REG_RESET 8'h00
`define SRAP_REG_COUNT 16
`endif

// ==== srap_pkg.sv ====
/*
 * types of the serial register-access port.
 * assumes srap_params.svh is included by its users.
 */
package srap_pkg;
    typedef enum logic [3:0] {
        SRAP_IDLE = 4'h1,
        SRAP_INSTR = 4'h2,
        SRAP_ADDR = 4'h4,
        SRAP_DATA = 4'h8
    } srap_phase_e;
endpackage

// ==== srap_sync.sv ====
/*
 * two-flop synchroniser for one asynchronous level.
 * both flops reset to RESET_VAL, the idle level of the pin, so no false edge follows reset.
 * assumes the input has no relation to core_clk.
 */
`timescale 1ns/10ps
module srap_sync #(
    parameter logic RESET_VAL = 1'b0
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic asyncIn,
    output logic syncOut
);
    typedef struct packed {
        logic first;
        logic second;
    } srap_sync_s;
    srap_sync_s state;
    srap_sync_s next_state;

    // first stage feeds only the second
    always_comb begin
        next_state.first = asyncIn;
        next_state.second = state.first;
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= '{first: RESET_VAL, second: RESET_VAL};
        end else begin
            state <= next_state;
        end
    end

    assign syncOut = state.second;
endmodule

// ==== srap_port_props.sv ====
/* port checks for srap_port.
   assumes a bind from the bench top. */
`timescale 1ns/10ps
module srap_port_props #(
    parameter int ADDR_BITS = 11,
    parameter int DATA_BITS = 8
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic chipSel_n,
    input wire logic serialClk,
    input wire logic serial_in_line,
    input wire logic serial_out_line,
    input wire logic serialOutEn_n,
    input wire logic [ADDR_BITS-1:0] lastAddr,
    input wire logic lastWasRead,
    input wire logic writeStrobe,
    input wire logic [DATA_BITS-1:0] writeData
);
    // one clock domain for every check
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    a_out_release: assert property ($rose(chipSel_n) |-> ##[1:6] serialOutEn_n)
        else $error("enable low after deselect");
    a_idle_quiet: assert property (chipSel_n [*6] |-> !writeStrobe)
        else $error("store while idle");
    a_strobe_once: assert property (writeStrobe |=> !writeStrobe)
        else $error("store pulse too long");
    a_strobe_dir: assert property (writeStrobe |-> !lastWasRead && serialOutEn_n)
        else $error("store on a read");
    a_data_cause: assert property ($changed(writeData) |-> writeStrobe)
        else $error("data moved without store");
    a_out_fall: assert property (!serialOutEn_n && $changed(serial_out_line)
        |-> !serialClk && !$past(serialClk, 2))
        else $error("out bit moved off a fall");
    a_enable_cause: assert property ($fell(serialOutEn_n)
        |-> !chipSel_n && lastWasRead)
        else $error("enable without read");
    a_out_off: assert property (serialOutEn_n && $past(serialOutEn_n)
        |-> !serial_out_line)
        else $error("out not zero when off");
endmodule

// ==== srap_host_model.sv ====
/* host model driving the serial pins.
   assumes core_clk at 100 MHz; serial clock is 160 ns, low when idle. */
`timescale 1ns/10ps
module srap_host_model (
    input wire logic core_clk,
    output logic chipSel_n,
    output logic serialClk,
    output logic serial_in_line,
    input wire logic serial_out_line
);
    // idle pins from time zero
    initial begin
        chipSel_n = 1'b1;
        serialClk = 1'b0;
        serial_in_line = 1'b0;
    end
    // half a serial period, moved just after a core edge
    task automatic half();
        repeat (8) @(posedge core_clk);
        #1;
    endtask
    // one frame msb first; n below 24 cuts it short, above 24 adds clocks with ones
    task automatic xfer(input logic [23:0] f, input int n, output logic [7:0] r);
        r = 8'h00;
        chipSel_n = 1'b0;
        half();
        for (int i = 0; i < n; i++) begin
            serial_in_line = (i < 24) ? f[23-i] : 1'b1;
            half();
            serialClk = 1'b1;
            r = {r[6:0], serial_out_line};
            half();
            serialClk = 1'b0;
        end
        half();
        chipSel_n = 1'b1;
        serial_in_line = ~serial_in_line; // released line must not look valid
        half();
    endtask
endmodule

// ==== tb.sv ====
/* bench top for srap_port with the host model.
   assumes srap_params.svh and the host model compile alongside. */
`timescale 1ns/10ps
`include "srap_params.svh"
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin bad_count++; \
    $display("Error %s exp %h got %h", n, e, s); end end
module tb;
    logic core_clk, rst_n, chipSel_n, serialClk, serial_in_line, serial_out_line;
    logic serialOutEn_n, lastWasRead, writeStrobe;
    logic [10:0] lastAddr;
    logic [7:0] writeData, rd;
    int bad_count = 0;
    int compares = 0;
    int strobes = 0;
    srap_port u_srap_port (.core_clk(core_clk), .rst_n(rst_n), .chipSel_n(chipSel_n),
        .serialClk(serialClk), .serial_in_line(serial_in_line),
        .serial_out_line(serial_out_line), .serialOutEn_n(serialOutEn_n), .lastAddr(lastAddr),
        .lastWasRead(lastWasRead), .writeStrobe(writeStrobe), .writeData(writeData));
    srap_host_model u_srap_host_model (.core_clk(core_clk), .chipSel_n(chipSel_n),
        .serialClk(serialClk), .serial_in_line(serial_in_line),
        .serial_out_line(serial_out_line));
    // core clock
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // count stored bytes
    always @(posedge core_clk) begin
        if (writeStrobe === 1'b1) strobes++;
    end
    // write frame; low instr bits set so only the top bit decides
    task automatic wr(input logic [10:0] a, input logic [7:0] d, input int n);
        int b;
        b = strobes;
        u_srap_host_model.xfer({5'h0f, a, d}, n, rd);
        `CHK("stores", (n >= 24) ? b + 1 : b, strobes)
        if (n >= 24) `CHK("wdata", d, writeData)
        `CHK("wdir", 1'b0, lastWasRead)
        `CHK("waddr", a, lastAddr)
    endtask
    task automatic rdchk(input logic [10:0] a, input logic [7:0] e);
        u_srap_host_model.xfer({5'h10, a, 8'h00}, 24, rd);
        `CHK("rdata", e, rd)
        `CHK("rdir", 1'b1, lastWasRead)
        `CHK("raddr", a, lastAddr)
        `CHK("oe off", 1'b1, serialOutEn_n)
    endtask
    task automatic t_reset();
        rdchk(11'h000, `SRAP_REG_RESET);
        rdchk(11'h7ff, `SRAP_REG_RESET);
    endtask
    // back to back writes, then read through an alias
    task automatic t_write_read();
        wr(11'h7f3, 8'ha5, 24);
        wr(11'h004, 8'h3c, 24);
        rdchk(11'h003, 8'ha5);
        rdchk(11'h004, 8'h3c);
    endtask
    // cut a write mid data; the register must keep its byte
    task automatic t_abort();
        wr(11'h004, 8'hff, 20);
        rdchk(11'h004, 8'h3c);
    endtask
    // extra clocks after a full write byte must not start a second frame
    task automatic t_overrun();
        wr(11'h005, 8'h69, 40);
        rdchk(11'h005, 8'h69);
        rdchk(11'h004, 8'h3c);
    endtask
    task automatic print_verdict();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // main sequence
    initial begin
        rst_n = 1'b0;
        repeat (8) @(posedge core_clk);
        #1 rst_n = 1'b1;
        repeat (4) @(posedge core_clk);
        #1;
        t_reset();
        t_write_read();
        t_abort();
        t_overrun();
        print_verdict();
    end
    // hang guard, ten times the run
    initial begin
        #500000;
        bad_count++;
        print_verdict();
    end
endmodule
bind srap_port srap_port_props #(.ADDR_BITS(ADDR_BITS), .DATA_BITS(DATA_BITS)) u_srap_port_props (
    .core_clk(core_clk), .rst_n(rst_n), .chipSel_n(chipSel_n), .serialClk(serialClk),
    .serial_in_line(serial_in_line), .serial_out_line(serial_out_line),
    .serialOutEn_n(serialOutEn_n), .lastAddr(lastAddr), .lastWasRead(lastWasRead),
    .writeStrobe(writeStrobe), .writeData(writeData));
